// [verilog/rbl_top.sv]
// front-panel supervision: reset button timing and device and port leds
//
// Operation
// - five-second hold then release loads defaults
// - short press and release requests a reboot
// - state led blinks once a second while pressed
// - state led steady green in normal running
// - state led blinks green while booting
// - state led steady red when initialisation failed
// - fault led dark in normal operation
// - first supply led amber when input powered
// - second supply led amber when input powered
// - green port led steady at gigabit link
// - green port led blinks with gigabit traffic
// - green port led dark when link down
// - copper amber steady at 10 or 100
// - copper amber blinks with low-speed traffic
// - copper amber dark when link down
// - fibre amber steady at 100 Mbps link
// - fibre amber blinks with 100 Mbps traffic
// - fibre amber dark when link down
`timescale 1ns/1ps
`include "rbl_defines.svh"
module rbl_top
  import rbl_pkg::*;
#(
  parameter int NUM_COPPER = 8,
  parameter int NUM_FIBRE = 2,
  parameter logic [31:0] HOLD_CYC = 32'(`RBL_CYC(`RBL_HOLD_MS)),
  parameter logic [31:0] STATE_HALF_CYC = 32'(`RBL_CYC(`RBL_STATE_HALF_MS)),
  parameter logic [31:0] ACT_HALF_CYC = 32'(`RBL_CYC(`RBL_ACT_HALF_MS)),
  parameter logic [31:0] DEBOUNCE_CYC = 32'(`RBL_CYC(`RBL_DEBOUNCE_MS))
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // button pin, asynchronous, low while pressed
  input wire logic reset_button_n,
  // supply detect pins, asynchronous, high while powered
  input wire logic supply_input_one,
  input wire logic supply_input_two,
  // system status from the management cpu, same clock
  input wire logic boot_done,
  input wire logic init_failed,
  // port status from the mac, same clock; copper first, then fibre modules
  input wire logic [NUM_COPPER+NUM_FIBRE-1:0] port_link_up,
  input wire logic [2*(NUM_COPPER+NUM_FIBRE)-1:0] port_speed,
  // traffic seen in this cycle, per port
  input wire logic [NUM_COPPER+NUM_FIBRE-1:0] port_activity,
  // system-state led pair, high lights
  output logic state_led_green,
  output logic state_led_red,
  // fault and supply leds, high lights
  output logic fault_led,
  output logic supply_one_led,
  output logic supply_two_led,
  // port leds, high lights
  output logic [NUM_COPPER+NUM_FIBRE-1:0] port_led_green,
  output logic [NUM_COPPER+NUM_FIBRE-1:0] port_led_amber,
  // requests to the system controller
  output logic reboot_req,
  output logic factory_reset_req,
  // debounced button level, high while held
  output logic button_held
);

  // ports in total, copper first
  localparam int NUM_PORTS = NUM_COPPER + NUM_FIBRE;

  // pin synchronisers
  logic btn_meta, btn_sync, next_btn_meta, next_btn_sync;
  logic sup1_meta, sup1_sync, next_sup1_meta, next_sup1_sync;
  logic sup2_meta, sup2_sync, next_sup2_meta, next_sup2_sync;

  // press edge detect
  logic held_d, next_held_d;
  logic press_edge;

  // blink generators
  logic [31:0] state_cnt, next_state_cnt;
  logic state_phase, next_state_phase;
  logic [31:0] act_cnt, next_act_cnt;
  logic act_phase, next_act_phase;
  logic act_tick;

  // device led next values
  logic next_state_led_green, next_state_led_red;
  logic next_supply_one_led, next_supply_two_led;
  logic next_fault_led;

  // per-port speed codes, unpacked once for the led pairs
  rbl_speed_e port_spd [NUM_PORTS];

  // speed code of one port from the packed status bus
  function automatic rbl_speed_e speed_of(input logic [2*NUM_PORTS-1:0] bus, input int idx);
    return rbl_speed_e'(bus[2*idx +: 2]);
  endfunction

  // next count of a wrapping blink counter
  function automatic logic [31:0] cnt_step(input logic [31:0] cnt, input logic [31:0] lim);
    return rbl_cnt_done(cnt, lim) ? `RBL_CNT_ZERO : cnt + `RBL_CNT_ONE;
  endfunction

  rbl_tick_if tick ();

  // button pin, inverted to pressed-high; first flop feeds only the second
  always_comb begin
    next_btn_meta = ~reset_button_n;
    next_btn_sync = btn_meta;
  end

  // button synchroniser registers
  always_ff @(posedge clk) begin
    if (reset) begin
      btn_meta <= 1'b0;
      btn_sync <= 1'b0;
    end else begin
      btn_meta <= next_btn_meta;
      btn_sync <= next_btn_sync;
    end
  end

  // first supply detect; no debounce, the led may flicker with a bad contact
  always_comb begin
    next_sup1_meta = supply_input_one;
    next_sup1_sync = sup1_meta;
  end

  // first supply synchroniser registers
  always_ff @(posedge clk) begin
    if (reset) begin
      sup1_meta <= 1'b0;
      sup1_sync <= 1'b0;
    end else begin
      sup1_meta <= next_sup1_meta;
      sup1_sync <= next_sup1_sync;
    end
  end

  // second supply detect, same two-flop scheme
  always_comb begin
    next_sup2_meta = supply_input_two;
    next_sup2_sync = sup2_meta;
  end

  // second supply synchroniser registers
  always_ff @(posedge clk) begin
    if (reset) begin
      sup2_meta <= 1'b0;
      sup2_sync <= 1'b0;
    end else begin
      sup2_meta <= next_sup2_meta;
      sup2_sync <= next_sup2_sync;
    end
  end

  // debounce and hold timing
  rbl_button #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .HOLD_CYC(HOLD_CYC)
  ) u_button (
    .clk(clk),
    .reset(reset),
    .btn_level(btn_sync),
    .pressed(button_held),
    .reboot_pulse(reboot_req),
    .factory_pulse(factory_reset_req)
  );

  // press edge; held_d resets low, the idle level of button_held, so no false edge
  always_comb begin
    next_held_d = button_held;
    press_edge = button_held && !held_d;
  end

  // press edge register
  always_ff @(posedge clk) begin
    if (reset) begin
      held_d <= 1'b0;
    end else begin
      held_d <= next_held_d;
    end
  end

  // one-second state blink; a new press restarts it lit so the user sees
  // the response at once rather than up to half a second later
  always_comb begin
    // free-running half-period count, wrapping at the limit
    next_state_cnt = cnt_step(state_cnt, STATE_HALF_CYC);
    next_state_phase = state_phase;
    if (press_edge) begin
      // restart the period lit at the press
      next_state_cnt = `RBL_CNT_ZERO;
      next_state_phase = 1'b1;
    end else if (rbl_cnt_done(state_cnt, STATE_HALF_CYC)) begin
      // half period over, swap the phase
      next_state_phase = ~state_phase;
    end
  end

  // state blink registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_cnt <= `RBL_CNT_ZERO;
      state_phase <= 1'b0;
    end else begin
      state_cnt <= next_state_cnt;
      state_phase <= next_state_phase;
    end
  end

  // free-running traffic blink shared by all ports, so busy ports flash together
  always_comb begin
    act_tick = rbl_cnt_done(act_cnt, ACT_HALF_CYC);
    next_act_cnt = cnt_step(act_cnt, ACT_HALF_CYC);
    // the phase only moves on a tick, so every port sees the same edges
    next_act_phase = act_tick ? ~act_phase : act_phase;
  end

  // traffic blink registers
  always_ff @(posedge clk) begin
    if (reset) begin
      act_cnt <= `RBL_CNT_ZERO;
      act_phase <= 1'b0;
    end else begin
      act_cnt <= next_act_cnt;
      act_phase <= next_act_phase;
    end
  end

  // hand the shared timing to every port through the carrier
  assign tick.act_tick = act_tick;
  assign tick.act_phase = act_phase;

  // state led priority: button, then init failure, then boot, then running
  always_comb begin
    next_state_led_green = 1'b0;
    next_state_led_red = 1'b0;
    if (button_held) begin
      // the phase as it will stand, so the press shows lit the next cycle
      next_state_led_green = next_state_phase;
    end else if (init_failed) begin
      // failed start: steady red, green off
      next_state_led_red = 1'b1;
    end else if (!boot_done) begin
      // still booting: the one-second blink
      next_state_led_green = state_phase;
    end else begin
      // normal running: steady green
      next_state_led_green = 1'b1;
    end
  end

  // state led registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_led_green <= 1'b0;
      state_led_red <= 1'b0;
    end else begin
      state_led_green <= next_state_led_green;
      state_led_red <= next_state_led_red;
    end
  end

  // supply leds follow the synchronised detect; the fault led has no use
  // yet, its red state is kept back, so it stays dark
  always_comb begin
    next_supply_one_led = sup1_sync;
    next_supply_two_led = sup2_sync;
    next_fault_led = 1'b0;
  end

  // supply and fault led registers
  always_ff @(posedge clk) begin
    if (reset) begin
      supply_one_led <= 1'b0;
      supply_two_led <= 1'b0;
      fault_led <= 1'b0;
    end else begin
      supply_one_led <= next_supply_one_led;
      supply_two_led <= next_supply_two_led;
      fault_led <= next_fault_led;
    end
  end

  // unpack the speed codes once; the led pairs see enum values only
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      port_spd[i] = speed_of(port_speed, i);
    end
  end

  // one led pair per port; fibre modules sit above the copper ports
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      // fibre ports know no 10 Mbps mode, the pair decides that itself
      rbl_port_led #(
        .IS_FIBRE(gi >= NUM_COPPER)
      ) u_port (
        .clk(clk),
        .reset(reset),
        .link_up(port_link_up[gi]),
        .speed(port_spd[gi]),
        .activity(port_activity[gi]),
        .tick(tick.snk),
        .led_green(port_led_green[gi]),
        .led_amber(port_led_amber[gi])
      );
    end
  endgenerate

endmodule // rbl_top

// [verilog/rbl_defines.svh]
// timing figures, reset values and rate for the reset button and led block
`ifndef RBL_DEFINES_SVH
`define RBL_DEFINES_SVH

// system clock rate in MHz (4 ns period)
`define RBL_CLK_MHZ 64'd250
// long hold for factory defaults, in ms (five seconds)
`define RBL_HOLD_MS 64'd5000
// half period of the system-state blink, in ms (one blink a second)
`define RBL_STATE_HALF_MS 64'd500
// half period of the traffic blink on port leds, in ms
`define RBL_ACT_HALF_MS 64'd50
// button contact must stay put this long before it counts, in ms
`define RBL_DEBOUNCE_MS 64'd10
// ms to clock cycles at the system rate
`define RBL_CYC(ms) ((ms) * 64'd1000 * `RBL_CLK_MHZ)

// counter reset and step values
`define RBL_CNT_ZERO 32'h0
`define RBL_CNT_ONE 32'h1

`endif

// [verilog/rbl_pkg.sv]
// types and shared helpers for the reset button and led block
package rbl_pkg;

  // link speed code reported per port
  typedef enum logic [1:0] {
    RBL_SPD_10   = 2'b00,
    RBL_SPD_100  = 2'b01,
    RBL_SPD_1000 = 2'b10,
    RBL_SPD_NONE = 2'b11
  } rbl_speed_e;

  // push-button timing states
  typedef enum logic [1:0] {
    RBL_BTN_IDLE  = 2'b00,
    RBL_BTN_SHORT = 2'b01,
    RBL_BTN_LONG  = 2'b10
  } rbl_btn_e;

  // true on the last cycle of a period of lim cycles (lim at least one)
  function automatic logic rbl_cnt_done(input logic [31:0] cnt, input logic [31:0] lim);
    return cnt >= (lim - 32'h1);
  endfunction

endpackage

// [verilog/rbl_tick_if.sv]
// traffic blink timing shared from the top to every port led
`timescale 1ns/1ps
interface rbl_tick_if;
  logic act_tick;
  logic act_phase;
  modport src (output act_tick, output act_phase);
  modport snk (input act_tick, input act_phase);
endinterface // rbl_tick_if

// [verilog/rbl_button.sv]
// debounce and hold timing of the recessed push-button
`timescale 1ns/1ps
`include "rbl_defines.svh"
module rbl_button
  import rbl_pkg::*;
#(
  parameter logic [31:0] DEBOUNCE_CYC = 32'h1,
  parameter logic [31:0] HOLD_CYC = 32'h1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // synchronised contact level, high while pressed
  input wire logic btn_level,
  // results
  output logic pressed,
  output logic reboot_pulse,
  output logic factory_pulse
);

  rbl_btn_e state, next_state;
  logic [31:0] db_cnt, next_db_cnt;
  logic [31:0] hold_cnt, next_hold_cnt;
  logic next_pressed, next_reboot_pulse, next_factory_pulse;

  // debounce, then time the hold from the accepted press edge
  always_comb begin
    next_db_cnt = `RBL_CNT_ZERO;
    next_pressed = pressed;
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_reboot_pulse = 1'b0;
    next_factory_pulse = 1'b0;
    if (btn_level != pressed) begin
      // a bounce resets the count, so only a steady level is accepted
      next_db_cnt = db_cnt + `RBL_CNT_ONE;
      if (rbl_cnt_done(db_cnt, DEBOUNCE_CYC)) begin
        next_pressed = btn_level;
        next_db_cnt = `RBL_CNT_ZERO;
      end
    end
    case (state)
      RBL_BTN_IDLE: begin
        next_hold_cnt = `RBL_CNT_ZERO;
        if (next_pressed) begin
          next_state = RBL_BTN_SHORT;
        end
      end
      RBL_BTN_SHORT: begin
        if (!next_pressed) begin
          next_reboot_pulse = 1'b1;
          next_state = RBL_BTN_IDLE;
        end else if (rbl_cnt_done(hold_cnt, HOLD_CYC)) begin
          next_state = RBL_BTN_LONG;
        end else begin
          next_hold_cnt = hold_cnt + `RBL_CNT_ONE;
        end
      end
      RBL_BTN_LONG: begin
        // defaults load on release, never while still held
        if (!next_pressed) begin
          next_factory_pulse = 1'b1;
          next_state = RBL_BTN_IDLE;
        end
      end
      default: begin
        next_state = RBL_BTN_IDLE;
      end
    endcase
  end

  // button state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= RBL_BTN_IDLE;
      db_cnt <= `RBL_CNT_ZERO;
      hold_cnt <= `RBL_CNT_ZERO;
      pressed <= 1'b0;
      reboot_pulse <= 1'b0;
      factory_pulse <= 1'b0;
    end else begin
      state <= next_state;
      db_cnt <= next_db_cnt;
      hold_cnt <= next_hold_cnt;
      pressed <= next_pressed;
      reboot_pulse <= next_reboot_pulse;
      factory_pulse <= next_factory_pulse;
    end
  end

endmodule // rbl_button

// [verilog/rbl_port_led.sv]
// link and traffic led pair of one copper or fibre-module port
`timescale 1ns/1ps
module rbl_port_led
  import rbl_pkg::*;
#(
  parameter bit IS_FIBRE = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // port status from the mac, same clock
  input wire logic link_up,
  input rbl_speed_e speed,
  input wire logic activity,
  // shared traffic blink timing
  rbl_tick_if.snk tick,
  // leds, high lights
  output logic led_green,
  output logic led_amber
);

  logic act_seen, next_act_seen;
  logic next_led_green, next_led_amber;
  logic blink_on, low_speed;

  // traffic is held until the next traffic tick, at most half a blink period
  always_comb begin
    next_act_seen = act_seen;
    if (tick.act_tick) begin
      next_act_seen = 1'b0;
    end
    if (activity) begin
      next_act_seen = 1'b1; // a new frame beats the period clear
    end
    blink_on = act_seen ? tick.act_phase : 1'b1;
    // fibre modules have no 10 Mbps mode, so that code stays dark
    low_speed = IS_FIBRE ? (speed == RBL_SPD_100)
                         : (speed == RBL_SPD_10 || speed == RBL_SPD_100);
    // steady when linked, blinking with traffic, dark when down
    next_led_green = link_up && speed == RBL_SPD_1000 && blink_on;
    // same scheme at the lower speeds
    next_led_amber = link_up && low_speed && blink_on;
  end

  // port led registers
  always_ff @(posedge clk) begin
    if (reset) begin
      act_seen <= 1'b0;
      led_green <= 1'b0;
      led_amber <= 1'b0;
    end else begin
      act_seen <= next_act_seen;
      led_green <= next_led_green;
      led_amber <= next_led_amber;
    end
  end

endmodule // rbl_port_led

// [testbench/rbl_top_asserts.sv]
// port assertions for the reset button and led block
`timescale 1ns/1ps
module rbl_top_asserts
  import rbl_pkg::*;
#(
  parameter int NUM_COPPER = 8,
  parameter int NUM_FIBRE = 2,
  parameter logic [31:0] HOLD_CYC = 32'h1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // watched inputs
  input wire logic supply_input_one,
  input wire logic supply_input_two,
  input wire logic boot_done,
  input wire logic init_failed,
  input wire logic [NUM_COPPER+NUM_FIBRE-1:0] port_link_up,
  input wire logic [2*(NUM_COPPER+NUM_FIBRE)-1:0] port_speed,
  // watched outputs
  input wire logic state_led_green,
  input wire logic state_led_red,
  input wire logic fault_led,
  input wire logic supply_one_led,
  input wire logic supply_two_led,
  input wire logic [NUM_COPPER+NUM_FIBRE-1:0] port_led_green,
  input wire logic [NUM_COPPER+NUM_FIBRE-1:0] port_led_amber,
  input wire logic reboot_req,
  input wire logic factory_reset_req,
  input wire logic button_held
);
  localparam int N = NUM_COPPER + NUM_FIBRE;
  logic [2:0] up_cnt, next_up_cnt;
  logic [31:0] held_len, next_held_len;
  logic held_q, next_held_q;
  logic [N-1:0] gig_q, low_q, next_gig_q, next_low_q;

  // age since reset, press length, speeds each led may show
  always_comb begin
    next_up_cnt = (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
    next_held_q = button_held;
    next_held_len = button_held ? (held_q ? held_len + 32'h1 : 32'h1) : held_len;
    for (int i = 0; i < N; i++) begin
      next_gig_q[i] = port_link_up[i] && (port_speed[2*i +: 2] == RBL_SPD_1000);
      next_low_q[i] = port_link_up[i] && ((port_speed[2*i +: 2] == RBL_SPD_100) ||
        (i < NUM_COPPER && port_speed[2*i +: 2] == RBL_SPD_10));
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (reset) begin
      up_cnt <= 3'h0;
      held_q <= 1'b0;
      held_len <= 32'h0;
      gig_q <= '0;
      low_q <= '0;
    end else begin
      up_cnt <= next_up_cnt;
      held_q <= next_held_q;
      held_len <= next_held_len;
      gig_q <= next_gig_q;
      low_q <= next_low_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_fault_dark: assert property (fault_led == 1'b0) else $error("fault lit");
  a_supply_one: assert property (
    up_cnt >= 3'h4 |-> supply_one_led == $past(supply_input_one, 3)) else $error("supply one");
  a_supply_two: assert property (
    up_cnt >= 3'h4 |-> supply_two_led == $past(supply_input_two, 3)) else $error("supply two");
  a_state_red: assert property (
    up_cnt >= 3'h2 && $past(init_failed) && !$past(button_held) |-> state_led_red &&
    !state_led_green) else $error("state red");
  a_state_run: assert property (
    up_cnt >= 3'h2 && $past(boot_done) && !$past(init_failed) && !$past(button_held) |->
    state_led_green && !state_led_red) else $error("state run");
  a_press_blink: assert property (
    $rose(button_held) |=> state_led_green) else $error("press blink");
  a_reboot_short: assert property (
    reboot_req |-> $fell(button_held) && held_len <= HOLD_CYC + 32'h2) else $error("reboot");
  a_factory_long: assert property (
    factory_reset_req |-> $fell(button_held) && held_len + 32'h2 >= HOLD_CYC)
    else $error("factory");
  a_green_gig: assert property (
    (port_led_green & ~gig_q) == '0) else $error("green speed");
  a_amber_low: assert property (
    (port_led_amber & ~low_q) == '0) else $error("amber speed");
endmodule // rbl_top_asserts

// [testbench/rbl_button_model.sv]
// recessed push-button with contact chatter, pulled up when open
`timescale 1ns/1ps
module rbl_button_model (
  // clock
  input wire logic clk,
  // finger on the button
  input wire logic press,
  // pin, low while pressed
  output logic reset_button_n
);
  logic last_press = 1'b0;
  logic [1:0] bounce = 2'h0;
  initial reset_button_n = 1'b1;
  // chatter four cycles on each change, shorter than any sane debounce
  always @(posedge clk) begin
    last_press <= press;
    if (press != last_press)
      bounce <= 2'h3;
    else if (bounce != 2'h0)
      bounce <= bounce - 2'h1;
    reset_button_n <= (press != last_press || bounce != 2'h0) ? ~reset_button_n : ~press;
  end
endmodule // rbl_button_model

// [testbench/tb.sv]
// self-checking bench for the reset button and led block
`timescale 1ns/1ps
module tb;
  import rbl_pkg::*;
  localparam int NC = 2;
  localparam int N = 3;
  logic clk, reset, press, btn_n, sup1, sup2, boot_done, init_failed;
  logic [N-1:0] link, act, g, a;
  logic [2*N-1:0] spd;
  logic st_g, st_r, fault, s1, s2, rb, fr, held;
  int bad_count = 0;
  int n_compared = 0;

  // far side and device
  rbl_button_model i_btn (.clk(clk), .press(press), .reset_button_n(btn_n));
  rbl_top #(.NUM_COPPER(NC), .NUM_FIBRE(1), .HOLD_CYC(32'd200), .STATE_HALF_CYC(32'd20),
    .ACT_HALF_CYC(32'd8), .DEBOUNCE_CYC(32'd4)) i_dut (.clk(clk), .reset(reset),
    .reset_button_n(btn_n), .supply_input_one(sup1), .supply_input_two(sup2),
    .boot_done(boot_done), .init_failed(init_failed), .port_link_up(link), .port_speed(spd),
    .port_activity(act), .state_led_green(st_g), .state_led_red(st_r), .fault_led(fault),
    .supply_one_led(s1), .supply_two_led(s2), .port_led_green(g), .port_led_amber(a),
    .reboot_req(rb), .factory_reset_req(fr), .button_held(held));

  task automatic print_verdict;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // lit cycles of one led, or of button_held for sel 4, over n cycles
  task automatic lit(input int sel, input int n, output int ones);
    ones = 0;
    repeat (n) begin
      cyc(1);
      ones += (sel == 0) ? st_g : (sel == 1) ? g[0] : (sel == 4) ? held : a[sel-1];
    end
  endtask

  // press for hold cycles, release, catch the one request
  task automatic push(input int hold, output int ones, output logic r, output logic f);
    r = 1'b0;
    f = 1'b0;
    @(posedge clk) press <= 1'b1;
    lit(0, hold, ones);
    @(posedge clk) press <= 1'b0;
    for (int i = 0; i < 40 && !(r || f); i++) begin
      cyc(1);
      r = rb;
      f = fr;
    end
    if (!(r || f)) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      print_verdict();
    end
    cyc(1);
    chk(8'({rb, fr}), 8'h0);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    int ones;
    logic r1, f1, eg, ea;
    reset = 1'b1;
    press = 1'b0;
    sup1 = 1'b0;
    sup2 = 1'b0;
    boot_done = 1'b0;
    init_failed = 1'b0;
    link = '0;
    act = '0;
    spd = '1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) {sup2, sup1} <= k[1:0];
      cyc(5);
      chk(8'({s2, s1}), 8'(k));
    end
    $display("supply leds done");
    lit(0, 60, ones);
    chk(8'(ones > 0 && ones < 60), 8'h1);
    @(posedge clk) boot_done <= 1'b1;
    cyc(3);
    lit(0, 20, ones);
    chk(8'(ones), 8'd20);
    chk(8'({st_r, fault}), 8'h0);
    @(posedge clk) init_failed <= 1'b1;
    cyc(3);
    chk(8'({st_g, st_r}), 8'h1);
    @(posedge clk) init_failed <= 1'b0;
    $display("state leds done");
    for (int p = 0; p < N; p++)
      for (int s = 0; s < 4; s++)
        for (int l = 0; l < 2; l++) begin
          @(posedge clk) link <= N'(l) << p;
          spd <= ~((2*N)'(2'h3 ^ s[1:0]) << (2*p));
          eg = (l == 1) && (s == 2);
          ea = (l == 1) && ((p < NC) ? (s <= 1) : (s == 1));
          cyc(3);
          chk(8'({g[p], a[p]}), 8'({eg, ea}));
        end
    $display("port link leds done");
    @(posedge clk) link <= '1;
    spd <= {2'h1, 2'h1, 2'h2};
    act <= '1;
    for (int k = 1; k < 4; k++) begin
      lit(k, 40, ones);
      chk(8'(ones > 0 && ones < 40), 8'h1);
    end
    @(posedge clk) act <= '0;
    cyc(40);
    chk(8'({g[0], a[1], a[2]}), 8'h7);
    $display("port traffic leds done");
    @(posedge clk) press <= 1'b1;
    @(posedge clk) press <= 1'b0;
    lit(4, 30, ones);
    chk(8'(ones), 8'h0);
    push(30, ones, r1, f1);
    chk(8'({r1, f1}), 8'h2);
    push(300, ones, r1, f1);
    chk(8'({r1, f1}), 8'h1);
    chk(8'(ones > 0 && ones < 300), 8'h1);
    $display("button done");
    print_verdict();
  end
endmodule // tb

bind rbl_top rbl_top_asserts #(.NUM_COPPER(NUM_COPPER), .NUM_FIBRE(NUM_FIBRE),
  .HOLD_CYC(HOLD_CYC)) i_chk (.clk(clk), .reset(reset), .supply_input_one(supply_input_one),
  .supply_input_two(supply_input_two), .boot_done(boot_done), .init_failed(init_failed),
  .port_link_up(port_link_up), .port_speed(port_speed), .state_led_green(state_led_green),
  .state_led_red(state_led_red), .fault_led(fault_led), .supply_one_led(supply_one_led),
  .supply_two_led(supply_two_led), .port_led_green(port_led_green),
  .port_led_amber(port_led_amber), .reboot_req(reboot_req),
  .factory_reset_req(factory_reset_req), .button_held(button_held));
